// >>> sim/mfi_led_board.sv
// Purpose: Board model: strap resistor and LEDs on the indicator pins
// Assumes: Each LED returns to the rail that its strap resistor uses
// Notes: Lit outputs are seen from the board, independent of the swap bit
`timescale 1ns/1ps
module mfi_led_board (
	input wire logic strap_up,
	input wire logic col_pin_out,
	input wire logic col_pin_oe,
	input wire logic indicator_pin_zero,
	output logic col_pin_in,
	output logic col_lit,
	output logic led0_lit
);
	// ****************************************
	// Pin levels and LED state
	// ****************************************
	// Released pin falls back to the strap resistor level
	assign col_pin_in = col_pin_oe ? col_pin_out : strap_up;
	// LED lights only while the pin is pulled against the strap rail
	assign col_lit = col_pin_oe && (col_pin_out != strap_up);
	assign led0_lit = indicator_pin_zero != strap_up;
endmodule : mfi_led_board

// >>> sim/mfi_top_test.sv
// Purpose: Self-checking bench for the indicator block
// Assumes: Zero wait state slave, short blink period
// Notes: LED state is judged through the board model
`timescale 1ns/1ps
module mfi_top_test
	import mfi_pkg::*;
();
	// ****************************************
	// Signals
	// ****************************************
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic hready;
	logic [7:0] st = 8'h0; // Status levels
	logic [2:0] ev = 3'h0; // Event pulses
	logic strap_up = 1'b1; // Board strap choice
	logic col_pin_in, col_pin_out, col_pin_oe, pin0, col_lit, led0_lit;
	int error_cnt = 0;
	int check_count = 0;
	int cyc = 0;
	logic [31:0] d;
	assign hready = hreadyout;
	always #20 hclk = ~hclk;
	// ****************************************
	// Design and board
	// ****************************************
	mfi_top #(.BLINK_CYCLES(8)) u_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .link_good(st[0]), .rx_act(st[1]),
		.tx_act(st[2]), .collision(st[3]), .speed100(st[4]),
		.full_duplex(st[5]), .lpi(st[6]), .mii_err(st[7]),
		.checker_err(ev[0]), .ctrl_reg_read(ev[1]),
		.self_test_clear(ev[2]), .col_pin_in(col_pin_in),
		.col_pin_out(col_pin_out), .col_pin_oe(col_pin_oe),
		.indicator_pin_zero(pin0));
	mfi_led_board u_board (.strap_up(strap_up), .col_pin_out(col_pin_out),
		.col_pin_oe(col_pin_oe), .indicator_pin_zero(pin0),
		.col_pin_in(col_pin_in), .col_lit(col_lit), .led0_lit(led0_lit));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic finish_test;
		if (error_cnt == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	// Hang guard
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic idle(input int n);
		repeat (n) @(posedge hclk);
	endtask : idle
	// Wait for an edge with hready sampled high
	task automatic rdy_edge;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask : rdy_edge
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk); // Idle gap so a read sees a prior write
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		rdy_edge();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy_edge();
		rd = hrdata;
	endtask : bus
	task automatic wr_ctrl(input logic [3:0] cfg, input logic [1:0] rt);
		bus(1'b1, ADDR_LED_CTRL, {22'h0, strap_up, 2'h0, cfg, 1'h0, rt}, d);
	endtask : wr_ctrl
	task automatic pulse(input int n);
		ev <= 3'h1 << n;
		@(posedge hclk);
		ev <= 3'h0;
		idle(4);
	endtask : pulse
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset(input logic sw);
		hresetn <= 1'b0;
		strap_up <= sw;
		st <= 8'h0;
		idle(8);
		hresetn <= 1'b1;
		idle(6);
		bus(1'b0, ADDR_LED_CTRL, 32'h0, d);
		check(d, {22'h0, sw, 9'h0});
		bus(1'b0, ADDR_LED_STAT, 32'h0, d);
		check(d, 32'h8);
	endtask : t_reset
	task automatic t_codes;
		logic [3:0] code [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
			4'h6, 4'h7, 4'h8, 4'ha, 4'hb, 4'hc};
		logic [7:0] hit [12] = '{8'h01, 8'h02, 8'h04, 8'h02, 8'h08, 8'h11,
			8'h01, 8'h20, 8'h01, 8'h31, 8'h40, 8'h80};
		logic [7:0] miss [12] = '{8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01,
			8'h11, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00};
		for (int i = 0; i < 12; i++) begin
			wr_ctrl(code[i], ROUTE_PIN0);
			st <= hit[i];
			idle(4);
			check(led0_lit, 1'b1);
			st <= miss[i];
			idle(4);
			check(led0_lit, 1'b0);
		end
	endtask : t_codes
	task automatic t_blink;
		int lit_n = 0;
		wr_ctrl(CFG_STRETCH, ROUTE_PIN0);
		st <= 8'h02; // One cycle of receive activity
		@(posedge hclk);
		st <= 8'h00;
		idle(3);
		check(led0_lit, 1'b1);
		idle(16);
		check(led0_lit, 1'b0);
		wr_ctrl(CFG_LINK_BLINK, ROUTE_PIN0);
		st <= 8'h05; // Link up, transmit busy
		idle(4);
		repeat (16) begin
			@(posedge hclk);
			lit_n += int'(led0_lit);
		end
		check(lit_n, 32'h8);
		st <= 8'h01;
		idle(16);
		check(led0_lit, 1'b1);
	endtask : t_blink
	task automatic t_route;
		wr_ctrl(CFG_LINK, ROUTE_COL);
		st <= 8'h1;
		idle(4);
		check({col_pin_oe, col_lit, led0_lit}, 3'b110);
		wr_ctrl(CFG_LINK, 2'h2);
		idle(4);
		check({col_pin_oe, col_lit, led0_lit}, 3'b000);
		wr_ctrl(CFG_LINK, ROUTE_PIN0);
		idle(4);
		check({col_pin_oe, col_lit, led0_lit}, 3'b001);
	endtask : t_route
	task automatic t_latches;
		wr_ctrl(CFG_LINK_LOST, ROUTE_PIN0);
		pulse(1);
		check(led0_lit, 1'b0);
		st <= 8'h0;
		idle(4);
		st <= 8'h1;
		idle(4);
		check(led0_lit, 1'b1);
		pulse(1);
		check(led0_lit, 1'b0);
		wr_ctrl(CFG_CHK_ERR, ROUTE_PIN0);
		pulse(2);
		pulse(0);
		idle(10);
		check(led0_lit, 1'b1);
		pulse(2);
		check(led0_lit, 1'b0);
		ev <= 3'h5; // Error and clear together: set wins
		@(posedge hclk);
		ev <= 3'h0;
		idle(4);
		check(led0_lit, 1'b1);
		pulse(2);
		check(led0_lit, 1'b0);
	endtask : t_latches
	task automatic t_misc;
		wr_ctrl(CFG_RSVD, ROUTE_PIN0);
		st <= 8'hff;
		idle(4);
		check(led0_lit, 1'b0);
		bus(1'b1, ADDR_LED_CTRL, 32'hffff_ffff, d);
		bus(1'b0, ADDR_LED_CTRL, 32'h0, d);
		check(d, {16'h0, LED_CTRL_MASK});
		bus(1'b0, 32'h0000_0100, 32'h0, d);
		check(d, 32'h0);
		check(hresp, 1'b0);
	endtask : t_misc
	task automatic t_active_high;
		t_reset(1'b0);
		wr_ctrl(CFG_LINK, ROUTE_PIN0);
		st <= 8'h1;
		idle(4);
		check({pin0, led0_lit}, 2'b11);
	endtask : t_active_high
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		t_reset(1'b1);
		t_codes();
		t_blink();
		t_route();
		t_latches();
		t_misc();
		t_active_high();
		finish_test();
	end
endmodule : mfi_top_test

// >>> verilog/mfi_pkg.sv
// Purpose: Shared constants for the multi-function indicator block
// Assumes: 25 MHz hclk, AHB-Lite word registers
// Notes: Register byte address is four times the register index
//
// What this block does
// - Collision pin strap sets indicator polarity default
// - Codes 0000/0001/0010: link, activity, transmit activity
// - Codes 0100-0111: collision, speed 100, 10, duplex
// - Codes 1000-1010: link blink, stretch, 100FD link
// - Codes 1011/1100: LPI, MII error; 1111 reserved
// - Link lost latches until control register read
// - Checker error latches until self test clear
// - Route 00 drives collision pin; 01/10 reserved
// - Route 11 drives indicator pin zero
package mfi_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int unsigned CLK_HZ = 25_000_000; // Core clock rate
	localparam int unsigned BLINK_MS = 50; // Blink half period in ms
	localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	localparam logic [1:0] STRAP_WAIT = 2'h2; // Sync settle edges

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [29:0] IDX_LED_CTRL = 30'h25; // Control index
	localparam logic [29:0] IDX_LED_STAT = 30'h26; // Status index
	localparam logic [31:0] ADDR_LED_CTRL = {IDX_LED_CTRL, 2'h0};
	localparam logic [31:0] ADDR_LED_STAT = {IDX_LED_STAT, 2'h0};
	localparam logic [15:0] LED_CTRL_RST = 16'h0000; // After reset
	localparam logic [15:0] LED_CTRL_MASK = 16'h027b; // Stored bits
	localparam int unsigned SWAP_BIT = 9; // Polarity swap
	localparam int unsigned CFG_LSB = 3; // Config field low bit
	localparam int unsigned ROUTE_LSB = 0; // Route field low bit

	// ****************************************
	// Field encodings
	// ****************************************
	localparam logic [3:0] CFG_LINK = 4'h0;
	localparam logic [3:0] CFG_ACT = 4'h1;
	localparam logic [3:0] CFG_TX_ACT = 4'h2;
	localparam logic [3:0] CFG_RX_ACT = 4'h3;
	localparam logic [3:0] CFG_COLL = 4'h4;
	localparam logic [3:0] CFG_SPD100 = 4'h5;
	localparam logic [3:0] CFG_SPD10 = 4'h6;
	localparam logic [3:0] CFG_FDX = 4'h7;
	localparam logic [3:0] CFG_LINK_BLINK = 4'h8;
	localparam logic [3:0] CFG_STRETCH = 4'h9;
	localparam logic [3:0] CFG_MII100FD = 4'ha;
	localparam logic [3:0] CFG_LPI = 4'hb;
	localparam logic [3:0] CFG_MII_ERR = 4'hc;
	localparam logic [3:0] CFG_LINK_LOST = 4'hd;
	localparam logic [3:0] CFG_CHK_ERR = 4'he;
	localparam logic [3:0] CFG_RSVD = 4'hf;
	localparam logic [1:0] ROUTE_COL = 2'h0;
	localparam logic [1:0] ROUTE_PIN0 = 2'h3;
endpackage : mfi_pkg

// >>> verilog/mfi_sel_if.sv
// Purpose: Carrier between register front end and selector
// Assumes: Single hclk domain
// Notes: Config in one direction, indicator state back
`timescale 1ns/1ps
interface mfi_sel_if;
	logic [3:0] cfg; // Selected indication
	logic ind; // Indicator on, before polarity
	logic lost; // Link lost latch
	logic chk; // Checker error latch
	modport ctrl (output cfg, input ind, lost, chk);
	modport sel (input cfg, output ind, lost, chk);
endinterface : mfi_sel_if

// >>> verilog/mfi_select.sv
// Purpose: Indication selector, latches and blink divider
// Assumes: Status inputs are synchronous to hclk
// Notes: Indicator is registered one edge after its cause
`timescale 1ns/1ps
module mfi_select
	import mfi_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	mfi_sel_if.sel sb,
	input wire logic link_good,
	input wire logic rx_act,
	input wire logic tx_act,
	input wire logic collision,
	input wire logic speed100,
	input wire logic full_duplex,
	input wire logic lpi,
	input wire logic mii_err,
	input wire logic checker_err,
	input wire logic ctrl_reg_read,
	input wire logic self_test_clear
);
	// ****************************************
	// Divider and activity
	// ****************************************
	logic [31:0] div_cnt; // Blink divider
	logic tick; // One-cycle blink enable
	logic phase; // Blink phase
	logic stretch; // Activity held to next tick
	logic link_prev; // Link of last cycle
	wire act = rx_act | tx_act;
	wire link_drop = link_prev & ~link_good;
	assign tick = (div_cnt == BLINK_CYCLES - 1);

	// Divider, phase and stretch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= 32'h0;
			phase <= 1'b0;
			stretch <= 1'b0;
			link_prev <= 1'b0;
		end else begin
			div_cnt <= tick ? 32'h0 : div_cnt + 32'h1;
			phase <= tick ? ~phase : phase;
			stretch <= act | (stretch & ~tick);
			link_prev <= link_good;
		end
	end

	// ****************************************
	// Latches and selection
	// ****************************************
	wire next_lost = link_drop | (sb.lost & ~ctrl_reg_read);
	wire next_chk = checker_err | (sb.chk & ~self_test_clear);

	// Pick the indication for a config code
	function automatic logic pick(input logic [3:0] c);
		unique case (c)
			CFG_LINK: pick = link_good;
			CFG_ACT: pick = act;
			CFG_TX_ACT: pick = tx_act;
			CFG_RX_ACT: pick = rx_act;
			CFG_COLL: pick = collision;
			CFG_SPD100: pick = link_good & speed100;
			CFG_SPD10: pick = link_good & ~speed100;
			CFG_FDX: pick = full_duplex;
			CFG_LINK_BLINK: pick = link_good & ~(stretch & phase);
			CFG_STRETCH: pick = stretch;
			CFG_MII100FD: pick = link_good & speed100 & full_duplex;
			CFG_LPI: pick = lpi;
			CFG_MII_ERR: pick = mii_err;
			CFG_LINK_LOST: pick = sb.lost;
			CFG_CHK_ERR: pick = sb.chk;
			CFG_RSVD: pick = 1'b0;
		endcase
	endfunction : pick

	wire next_ind = pick(sb.cfg);

	// Indicator and latches
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sb.ind <= 1'b0;
			sb.lost <= 1'b0;
			sb.chk <= 1'b0;
		end else begin
			sb.ind <= next_ind;
			sb.lost <= next_lost;
			sb.chk <= next_chk;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_drop;
		link_prev && !link_good;
	endsequence
	sequence s_hold_lost;
		sb.lost && !ctrl_reg_read;
	endsequence
	chk_link_follow: assert property (
		sb.cfg == CFG_LINK |=> sb.ind == $past(link_good))
		else $error("indicator does not follow link");
	chk_speed_follow: assert property (
		sb.cfg == CFG_SPD100 |=> sb.ind == $past(link_good & speed100))
		else $error("indicator does not follow speed");
	chk_fdx_link: assert property (
		sb.cfg == CFG_MII100FD
		|=> sb.ind == $past(link_good & speed100 & full_duplex))
		else $error("indicator does not follow 100FD link");
	chk_rsvd_off: assert property (
		sb.cfg == CFG_RSVD |=> !sb.ind)
		else $error("reserved config lit the indicator");
	chk_lost_set: assert property (
		(s_drop or s_hold_lost) |=> sb.lost)
		else $error("link lost latch dropped early");
	chk_chk_hold: assert property (
		checker_err ##1 (!self_test_clear)[*2] |=> sb.chk)
		else $error("checker latch not held");
	chk_rx_only: assert property (
		sb.cfg == CFG_RX_ACT |=> sb.ind == $past(rx_act))
		else $error("indicator does not follow receive");
endmodule : mfi_select

// >>> verilog/mfi_top.sv
// Purpose: Multi-function indicator with AHB-Lite registers
// Assumes: Status inputs on hclk; collision pin strap at reset
// Notes: Slave answers with zero wait states
`timescale 1ns/1ps
module mfi_top
	import mfi_pkg::*;
#(
	parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic link_good,
	input wire logic rx_act,
	input wire logic tx_act,
	input wire logic collision,
	input wire logic speed100,
	input wire logic full_duplex,
	input wire logic lpi,
	input wire logic mii_err,
	input wire logic checker_err,
	input wire logic ctrl_reg_read,
	input wire logic self_test_clear,
	input wire logic col_pin_in,
	output logic col_pin_out,
	output logic col_pin_oe,
	output logic indicator_pin_zero
);
	// ****************************************
	// Bus front end
	// ****************************************
	logic [15:0] ctrl; // Indicator control register
	logic [31:0] addr_q; // Data phase address
	logic wr_q; // Data phase is a write
	logic [15:0] stat; // Status view
	wire take = hsel & htrans[1] & hready; // Address phase taken
	wire wr_ctrl = wr_q & (addr_q == ADDR_LED_CTRL);
	wire [15:0] next_ctrl_wr = hwdata[15:0] & LED_CTRL_MASK;
	wire [3:0] cfg = ctrl[CFG_LSB +: 4];
	wire [1:0] route = ctrl[ROUTE_LSB +: 2];
	wire swap = ctrl[SWAP_BIT];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Decode the read word for an address
	function automatic logic [31:0] rd_word(input logic [31:0] a,
		input logic [15:0] c, input logic [15:0] s);
		if (a == ADDR_LED_CTRL)
			rd_word = {16'h0, c};
		else if (a == ADDR_LED_STAT)
			rd_word = {16'h0, s};
		else
			rd_word = 32'h0;
	endfunction : rd_word

	wire [31:0] next_rdata = rd_word(haddr, ctrl, stat);

	// Address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 32'h0;
			wr_q <= 1'b0;
			hrdata <= 32'h0;
		end else begin
			wr_q <= take & hwrite;
			addr_q <= take ? haddr : addr_q;
			hrdata <= (take & ~hwrite) ? next_rdata : hrdata;
		end
	end

	// ****************************************
	// Strap capture
	// ****************************************
	logic col_s1; // Sync stage one
	logic col_s2; // Sync stage two
	logic [1:0] strap_cnt; // Settle counter
	logic strap_done; // Strap taken
	wire strap_load = ~strap_done & (strap_cnt == STRAP_WAIT);
	// Counter freezes once the strap is loaded
	wire [1:0] next_strap_cnt = (strap_done | strap_load) ? strap_cnt :
		strap_cnt + 2'h1;

	// Synchronise the pin and count settle edges
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			col_s1 <= 1'b0;
			col_s2 <= 1'b0;
			strap_cnt <= 2'h0;
			strap_done <= 1'b0;
		end else begin
			col_s1 <= col_pin_in;
			col_s2 <= col_s1;
			strap_cnt <= next_strap_cnt;
			strap_done <= strap_done | strap_load;
		end
	end

	// Control register, strap loads polarity once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl <= LED_CTRL_RST;
		end else if (strap_load) begin
			ctrl[SWAP_BIT] <= col_s2;
		end else if (wr_ctrl) begin
			ctrl <= next_ctrl_wr;
		end
	end

	// ****************************************
	// Selector and pins
	// ****************************************
	mfi_sel_if sb ();
	assign sb.cfg = cfg;
	assign stat = {12'h0, strap_done, sb.chk, sb.lost, sb.ind};

	mfi_select #(
		.BLINK_CYCLES(BLINK_CYCLES)
	) u_sel (
		.hclk(hclk),
		.hresetn(hresetn),
		.sb(sb),
		.link_good(link_good),
		.rx_act(rx_act),
		.tx_act(tx_act),
		.collision(collision),
		.speed100(speed100),
		.full_duplex(full_duplex),
		.lpi(lpi),
		.mii_err(mii_err),
		.checker_err(checker_err),
		.ctrl_reg_read(ctrl_reg_read),
		.self_test_clear(self_test_clear)
	);

	wire lit = sb.ind ^ swap; // Pin level, swap means active low
	wire to_col = strap_done & (route == ROUTE_COL);
	wire to_pin0 = route == ROUTE_PIN0;
	wire next_col = to_col ? lit : swap;
	wire next_pin0 = to_pin0 ? lit : swap;

	// Registered pin drive
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			col_pin_out <= 1'b0;
			col_pin_oe <= 1'b0;
			indicator_pin_zero <= 1'b0;
		end else begin
			col_pin_out <= next_col;
			col_pin_oe <= to_col;
			indicator_pin_zero <= next_pin0;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// Strap load edge
	sequence s_strap;
		strap_load;
	endsequence

	// Read address phase aimed at the control word
	sequence s_ctrl_read;
		take && !hwrite && haddr == ADDR_LED_CTRL;
	endsequence

	// Polarity bit copies the synchronised strap
	chk_strap_polarity: assert property (
		s_strap |=> swap == $past(col_s2))
		else $error("polarity not taken from strap");

	// Strap is taken once per reset
	chk_strap_once: assert property (
		strap_done |-> !strap_load)
		else $error("strap taken twice");

	// Pin stays released until the strap is in
	chk_strap_free: assert property (
		!strap_done |=> !col_pin_oe)
		else $error("collision pin driven before strap taken");

	// Control word reads back through the bus
	chk_ctrl_read: assert property (
		s_ctrl_read |=> hrdata == {16'h0, $past(ctrl)})
		else $error("control read returned a wrong word");

	// Route 00 drives the collision pin
	chk_col_route: assert property (
		strap_done && route == ROUTE_COL
		|=> col_pin_oe && col_pin_out == $past(lit))
		else $error("collision pin not driven by indicator");

	// Other routes release the collision pin
	chk_rsvd_route: assert property (
		route != ROUTE_COL |=> !col_pin_oe)
		else $error("collision pin driven off route");

	// Route 11 drives pin zero
	chk_pin0_route: assert property (
		route == ROUTE_PIN0 |=> indicator_pin_zero == $past(lit))
		else $error("pin zero not driven by indicator");

	// Pin zero rests at its off level otherwise
	chk_pin0_idle: assert property (
		route != ROUTE_PIN0 |=> indicator_pin_zero == $past(swap))
		else $error("pin zero not at its off level");

	// Software write lands unless the strap loads
	chk_ctrl_write: assert property (
		wr_ctrl && !strap_load |=> ctrl == $past(next_ctrl_wr))
		else $error("control write not stored");
endmodule : mfi_top
